// *** hw/rssa_alu.sv ***
/*
 * Execution slice for rotates, subtract-with-borrow and decrement-and-skip.
 * Assumes: the core presents one operation with its accumulator, memory
 * operand and carry, holds it only while op_ready is high, and applies the
 * registered write enables to the accumulator, data memory and flags.
 */
// Operation
// - memory rotate left through carry, carry only
// - accumulator rotate left carry, memory kept
// - memory rotate right, no flag changes
// - accumulator rotate right, memory and flags kept
// - memory rotate right through carry, carry only
// - accumulator rotate right carry, memory kept
// - acc minus operand minus not carry, flags
// - carry cleared on borrow, else set
// - same subtraction written into memory, flags
// - memory decrement, write back, no flags
// - zero result skips via dummy cycle
// - accumulator decrement, skip on zero, no flags
// - accumulator decrement keeps memory, skip one dummy cycle
`timescale 1ns/1ns
`default_nettype none

module rssa_alu
  import rssa_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // issue
  input  wire logic       op_valid,
  input  wire rssa_op_t   op_code,
  output logic            op_ready,
  // operands
  input  wire logic [7:0] accumulator,
  input  wire logic [7:0] mem_operand,
  input  wire logic       carry_flag,
  // accumulator write
  output logic      [7:0] acc_result,
  output logic            acc_we,
  // data memory write
  output logic      [7:0] mem_result,
  output logic            mem_we,
  // flag writes
  output logic            carry_result,
  output logic            carry_we,
  output logic            overflow_flag,
  output logic            auxiliary_carry_flag,
  output logic            zero_flag,
  output logic            arith_flags_we,
  // sequencing
  output logic            skip_req,
  output logic            op_done
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] rot_left_carry(input logic [7:0] v, input logic c);
    rot_left_carry = {v[MSB:LSB], c};           // {new carry, new byte}
  endfunction

  function automatic logic [8:0] rot_right_carry(input logic [7:0] v, input logic c);
    rot_right_carry = {v[LSB], c, v[MSB:LSB + 1]};
  endfunction

  function automatic logic [7:0] rot_right(input logic [7:0] v);
    rot_right = {v[LSB], v[MSB:LSB + 1]};
  endfunction

  // ****************************************
  // state
  // ****************************************
  rssa_state_t state_ff, nxt_state;
  logic        ready_ff, nxt_ready;
  logic [7:0]  acc_ff, nxt_acc;
  logic        acc_we_ff, nxt_acc_we;
  logic [7:0]  mem_ff, nxt_mem;
  logic        mem_we_ff, nxt_mem_we;
  logic        carry_ff, nxt_carry;
  logic        carry_we_ff, nxt_carry_we;
  logic        ov_ff, nxt_ov;
  logic        ac_ff, nxt_ac;
  logic        z_ff, nxt_z;
  logic        arith_we_ff, nxt_arith_we;
  logic        skip_ff, nxt_skip;
  logic        done_ff, nxt_done;

  logic [7:0]  sub_diff;
  logic        sub_carry;
  logic        sub_ac;
  logic        sub_ov;
  logic        sub_z;
  logic [8:0]  rot_tmp;
  logic [7:0]  dec_val;
  logic        take;

  rssa_subtractor u_sub (
    .minuend       (accumulator),
    .subtrahend    (mem_operand),
    .carry_in      (carry_flag),
    .difference    (sub_diff),
    .carry_out     (sub_carry),
    .aux_carry_out (sub_ac),
    .overflow_out  (sub_ov),
    .zero_out      (sub_z)
  );

  // ****************************************
  // next-value logic
  // ****************************************
  always_comb begin
    take         = op_valid && ready_ff;
    dec_val      = mem_operand - ONE;
    rot_tmp      = {FLAG_RST, DATA_RST};
    nxt_state    = ST_EXEC;
    nxt_acc      = acc_ff;
    nxt_mem      = mem_ff;
    nxt_carry    = carry_ff;
    nxt_ov       = ov_ff;
    nxt_ac       = ac_ff;
    nxt_z        = z_ff;
    nxt_acc_we   = 1'b0;
    nxt_mem_we   = 1'b0;
    nxt_carry_we = 1'b0;
    nxt_arith_we = 1'b0;
    nxt_skip     = 1'b0;
    nxt_done     = 1'b0;
    // only one dummy cycle is needed, so the dummy state always returns
    if (state_ff == ST_DUMMY) begin
      nxt_done = 1'b1;
    end else if (take) begin
      nxt_done = 1'b1;
      unique case (op_code)
        OP_ROTATE_LEFT_CARRY_MEM: begin
          rot_tmp      = rot_left_carry(mem_operand, carry_flag);
          nxt_mem      = rot_tmp[MSB:LSB];
          nxt_carry    = rot_tmp[DATA_W];
          nxt_mem_we   = 1'b1;
          nxt_carry_we = 1'b1;
        end
        OP_ROTATE_LEFT_CARRY_TO_ACC: begin
          rot_tmp      = rot_left_carry(mem_operand, carry_flag);
          nxt_acc      = rot_tmp[MSB:LSB];
          nxt_carry    = rot_tmp[DATA_W];
          nxt_acc_we   = 1'b1;
          nxt_carry_we = 1'b1;
        end
        OP_ROTATE_RIGHT_MEM: begin
          nxt_mem    = rot_right(mem_operand);
          nxt_mem_we = 1'b1;
        end
        OP_ROTATE_RIGHT_TO_ACC: begin
          nxt_acc    = rot_right(mem_operand);
          nxt_acc_we = 1'b1;
        end
        OP_ROTATE_RIGHT_CARRY_MEM: begin
          rot_tmp      = rot_right_carry(mem_operand, carry_flag);
          nxt_mem      = rot_tmp[MSB:LSB];
          nxt_carry    = rot_tmp[DATA_W];
          nxt_mem_we   = 1'b1;
          nxt_carry_we = 1'b1;
        end
        OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
          rot_tmp      = rot_right_carry(mem_operand, carry_flag);
          nxt_acc      = rot_tmp[MSB:LSB];
          nxt_carry    = rot_tmp[DATA_W];
          nxt_acc_we   = 1'b1;
          nxt_carry_we = 1'b1;
        end
        OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
          nxt_acc      = sub_diff;
          nxt_mem      = sub_diff;
          nxt_acc_we   = (op_code == OP_SUBTRACT_BORROW_TO_ACC);
          nxt_mem_we   = (op_code == OP_SUBTRACT_BORROW_TO_MEM);
          nxt_carry    = sub_carry;
          nxt_ov       = sub_ov;
          nxt_ac       = sub_ac;
          nxt_z        = sub_z;
          nxt_carry_we = 1'b1;
          nxt_arith_we = 1'b1;
        end
        OP_DECREMENT_SKIP_ZERO_MEM, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
          nxt_mem    = dec_val;
          nxt_acc    = dec_val;
          nxt_mem_we = (op_code == OP_DECREMENT_SKIP_ZERO_MEM);
          nxt_acc_we = (op_code == OP_DECREMENT_SKIP_ZERO_TO_ACC);
          nxt_skip   = (dec_val == DATA_RST);
          // a non-zero result finishes at once; zero waits out the dummy fetch
          nxt_done   = (dec_val != DATA_RST);
          nxt_state  = (dec_val == DATA_RST) ? ST_DUMMY : ST_EXEC;
        end
        default: begin
          nxt_done = 1'b0;
        end
      endcase
    end
    nxt_ready = (nxt_state == ST_EXEC);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff    <= ST_EXEC;
      ready_ff    <= 1'b1;
      acc_ff      <= DATA_RST;
      mem_ff      <= DATA_RST;
      carry_ff    <= FLAG_RST;
      ov_ff       <= FLAG_RST;
      ac_ff       <= FLAG_RST;
      z_ff        <= FLAG_RST;
      acc_we_ff   <= 1'b0;
      mem_we_ff   <= 1'b0;
      carry_we_ff <= 1'b0;
      arith_we_ff <= 1'b0;
      skip_ff     <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      ready_ff    <= nxt_ready;
      acc_ff      <= nxt_acc;
      mem_ff      <= nxt_mem;
      carry_ff    <= nxt_carry;
      ov_ff       <= nxt_ov;
      ac_ff       <= nxt_ac;
      z_ff        <= nxt_z;
      acc_we_ff   <= nxt_acc_we;
      mem_we_ff   <= nxt_mem_we;
      carry_we_ff <= nxt_carry_we;
      arith_we_ff <= nxt_arith_we;
      skip_ff     <= nxt_skip;
      done_ff     <= nxt_done;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign op_ready             = ready_ff;
  assign acc_result           = acc_ff;
  assign acc_we               = acc_we_ff;
  assign mem_result           = mem_ff;
  assign mem_we               = mem_we_ff;
  assign carry_result         = carry_ff;
  assign carry_we             = carry_we_ff;
  assign overflow_flag        = ov_ff;
  assign auxiliary_carry_flag = ac_ff;
  assign zero_flag            = z_ff;
  assign arith_flags_we       = arith_we_ff;
  assign skip_req             = skip_ff;
  assign op_done              = done_ff;

endmodule

`default_nettype wire

// *** hw/rssa_pkg.sv ***
/*
 * Shared constants and types for the rotate / subtract-with-borrow /
 * decrement-and-skip execution slice of the 8-bit core.
 * Assumes the core decodes instructions into rssa_op_t before issue.
 */
package rssa_pkg;

  // ****************************************
  // widths and bit positions
  // ****************************************
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned MSB     = 7;
  localparam int unsigned LSB     = 0;
  localparam int unsigned NIB_MSB = 3;

  // ****************************************
  // reset values and the decrement step
  // ****************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic       FLAG_RST = 1'b0;
  localparam logic [7:0] ONE      = 8'h01;

  // ****************************************
  // timing: cycles of the dummy fetch on a skip
  // ****************************************
  localparam int unsigned SKIP_DUMMY_CYCLES = 1;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_ROTATE_LEFT_CARRY_MEM,
    OP_ROTATE_LEFT_CARRY_TO_ACC,
    OP_ROTATE_RIGHT_MEM,
    OP_ROTATE_RIGHT_TO_ACC,
    OP_ROTATE_RIGHT_CARRY_MEM,
    OP_ROTATE_RIGHT_CARRY_TO_ACC,
    OP_SUBTRACT_BORROW_TO_ACC,
    OP_SUBTRACT_BORROW_TO_MEM,
    OP_DECREMENT_SKIP_ZERO_MEM,
    OP_DECREMENT_SKIP_ZERO_TO_ACC
  } rssa_op_t;

  typedef enum logic {
    ST_EXEC,
    ST_DUMMY
  } rssa_state_t;

endpackage

// *** hw/rssa_subtractor.sv ***
/*
 * Subtract-with-borrow arithmetic: acc - operand - not(carry).
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ns
`default_nettype none

module rssa_subtractor
  import rssa_pkg::*;
(
  // operands
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  // results
  output logic      [7:0] difference,
  output logic            carry_out,
  output logic            aux_carry_out,
  output logic            overflow_out,
  output logic            zero_out
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // two's complement add of the inverted operand; carry set means no borrow
  always_comb begin
    full_sum      = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low_sum       = {1'b0, minuend[NIB_MSB:LSB]} + {1'b0, ~subtrahend[NIB_MSB:LSB]} + {4'h0, carry_in};
    difference    = full_sum[MSB:LSB];
    carry_out     = full_sum[DATA_W];
    aux_carry_out = low_sum[NIB_MSB + 1];
    overflow_out  = (minuend[MSB] != subtrahend[MSB]) && (full_sum[MSB] != minuend[MSB]);
    zero_out      = (full_sum[MSB:LSB] == DATA_RST);
  end

endmodule

`default_nettype wire

// *** testbench/rssa_alu_asserts.sv ***
/* Checker of rssa_alu results, strobes and skip timing.
   Assumes it is bound onto rssa_alu and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module rssa_alu_asserts
  import rssa_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // issue
  input wire logic       op_valid,
  input wire rssa_op_t   op_code,
  input wire logic       op_ready,
  // operands
  input wire logic [7:0] accumulator,
  input wire logic [7:0] mem_operand,
  input wire logic       carry_flag,
  // results
  input wire logic [7:0] acc_result,
  input wire logic       acc_we,
  input wire logic [7:0] mem_result,
  input wire logic       mem_we,
  input wire logic       carry_result,
  input wire logic       carry_we,
  input wire logic       arith_flags_we,
  input wire logic       skip_req,
  input wire logic       op_done
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = op_valid && op_ready;
  sequence skip_s;
    skip_req && !op_ready && !op_done ##1 op_done && op_ready && !skip_req;
  endsequence
  rlc_mem_a: assert property (tk && op_code == OP_ROTATE_LEFT_CARRY_MEM |=>
    mem_we && !acc_we && carry_we && !arith_flags_we && carry_result == $past(mem_operand[7])
    && mem_result == {$past(mem_operand[6:0]), $past(carry_flag)}) else $error("rotate left mem wrong");
  rlc_acc_a: assert property (tk && op_code == OP_ROTATE_LEFT_CARRY_TO_ACC |=>
    acc_we && !mem_we && carry_we && acc_result == {$past(mem_operand[6:0]), $past(carry_flag)})
    else $error("rotate left acc wrong");
  rr_mem_a: assert property (tk && op_code == OP_ROTATE_RIGHT_MEM |=>
    mem_we && !carry_we && !arith_flags_we && mem_result == {$past(mem_operand[0]), $past(mem_operand[7:1])})
    else $error("rotate right mem wrong");
  rrc_acc_a: assert property (tk && op_code == OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
    acc_we && !mem_we && carry_result == $past(mem_operand[0])
    && acc_result == {$past(carry_flag), $past(mem_operand[7:1])}) else $error("rotate right acc wrong");
  sub_acc_a: assert property (tk && op_code == OP_SUBTRACT_BORROW_TO_ACC |=>
    acc_we && arith_flags_we && carry_we && acc_result == $past(accumulator - mem_operand - {7'h00, ~carry_flag})
    && carry_result == $past({1'b0, accumulator} >= {1'b0, mem_operand} + {8'h00, ~carry_flag}))
    else $error("subtract to acc wrong");
  sub_mem_a: assert property (tk && op_code == OP_SUBTRACT_BORROW_TO_MEM |=>
    mem_we && !acc_we && arith_flags_we && mem_result == $past(accumulator - mem_operand - {7'h00, ~carry_flag}))
    else $error("subtract to mem wrong");
  dec_skip_a: assert property (tk && mem_operand == 8'h01 &&
    (op_code == OP_DECREMENT_SKIP_ZERO_MEM || op_code == OP_DECREMENT_SKIP_ZERO_TO_ACC) |=> skip_s)
    else $error("skip timing wrong");
  dec_one_a: assert property (tk && mem_operand != 8'h01 && op_code == OP_DECREMENT_SKIP_ZERO_TO_ACC |=>
    acc_we && !mem_we && !carry_we && !arith_flags_we && !skip_req && op_done
    && acc_result == $past(mem_operand) - 8'h01) else $error("acc decrement wrong");
endmodule

bind rssa_alu rssa_alu_asserts i_chk (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
  .op_ready(op_ready), .accumulator(accumulator), .mem_operand(mem_operand), .carry_flag(carry_flag),
  .acc_result(acc_result), .acc_we(acc_we), .mem_result(mem_result), .mem_we(mem_we),
  .carry_result(carry_result), .carry_we(carry_we), .arith_flags_we(arith_flags_we),
  .skip_req(skip_req), .op_done(op_done));
`default_nettype wire

// *** testbench/rssa_alu_bench.sv ***
/* Self-checking bench for rssa_alu.
   Assumes rssa_pkg, the design and its checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module rssa_alu_bench
  import rssa_pkg::*;
;
  logic       ref_clk, rst, op_valid, carry_flag, op_ready, acc_we, mem_we, carry_result, carry_we;
  logic       overflow_flag, auxiliary_carry_flag, zero_flag, arith_flags_we, skip_req, op_done;
  rssa_op_t   op_code;
  logic [7:0] accumulator, mem_operand, acc_result, mem_result;
  logic [5:0] st;
  logic [7:0] fl;
  int         n_fail, checks, cyc;
  assign st = {acc_we, mem_we, carry_we, arith_flags_we, skip_req, op_done};
  assign fl = {4'h0, overflow_flag, auxiliary_carry_flag, zero_flag, carry_result};
  rssa_alu i_dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .accumulator(accumulator), .mem_operand(mem_operand), .carry_flag(carry_flag), .acc_result(acc_result),
    .acc_we(acc_we), .mem_result(mem_result), .mem_we(mem_we), .carry_result(carry_result),
    .carry_we(carry_we), .overflow_flag(overflow_flag), .auxiliary_carry_flag(auxiliary_carry_flag),
    .zero_flag(zero_flag), .arith_flags_we(arith_flags_we), .skip_req(skip_req), .op_done(op_done));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // valid is left high so ops run back to back
  task automatic run(input rssa_op_t o, input logic [7:0] a, input logic [7:0] m, input logic c,
                     input logic [5:0] s);
    op_valid = 1'b1;
    op_code = o;
    accumulator = a;
    mem_operand = m;
    carry_flag = c;
    @(negedge ref_clk);
    chk({2'h0, st}, {2'h0, s});
  endtask
  task automatic idle;
    op_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rot;
    run(OP_ROTATE_LEFT_CARRY_MEM, 8'h00, 8'h81, 1'b0, 6'h19);
    chk(mem_result, 8'h02);
    chk(fl & 8'h01, 8'h01);
    run(OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h00, 8'h40, 1'b1, 6'h29);
    chk(acc_result, 8'h81);
    chk(fl & 8'h01, 8'h00);
    run(OP_ROTATE_RIGHT_MEM, 8'h00, 8'h01, 1'b1, 6'h11);
    chk(mem_result, 8'h80);
    run(OP_ROTATE_RIGHT_TO_ACC, 8'h00, 8'h02, 1'b1, 6'h21);
    chk(acc_result, 8'h01);
    run(OP_ROTATE_RIGHT_CARRY_MEM, 8'h00, 8'h01, 1'b0, 6'h19);
    chk(mem_result, 8'h00);
    chk(fl & 8'h01, 8'h01);
    run(OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h00, 8'h02, 1'b1, 6'h29);
    chk(acc_result, 8'h81);
    idle();
  endtask
  task automatic t_sub;
    run(OP_SUBTRACT_BORROW_TO_ACC, 8'h05, 8'h03, 1'b1, 6'h2D);
    chk(acc_result, 8'h02);
    chk(fl, 8'h05);
    run(OP_SUBTRACT_BORROW_TO_MEM, 8'h03, 8'h05, 1'b1, 6'h1D);
    chk(mem_result, 8'hFE);
    chk(fl, 8'h00);
    run(OP_SUBTRACT_BORROW_TO_ACC, 8'h80, 8'h00, 1'b0, 6'h2D);
    chk(acc_result, 8'h7F);
    chk(fl, 8'h09);
    run(OP_SUBTRACT_BORROW_TO_MEM, 8'h05, 8'h04, 1'b0, 6'h1D);
    chk(mem_result, 8'h00);
    chk(fl, 8'h07);
    idle();
  endtask
  task automatic t_dec;
    run(OP_DECREMENT_SKIP_ZERO_MEM, 8'h00, 8'h01, 1'b0, 6'h12);
    chk(mem_result, 8'h00);
    chk({7'h00, op_ready}, 8'h00);
    // this op lands in the dummy cycle and must be dropped
    op_code = OP_ROTATE_LEFT_CARRY_MEM;
    @(negedge ref_clk);
    chk({2'h0, st}, 8'h01);
    idle();
    chk({2'h0, st}, 8'h00);
    run(OP_DECREMENT_SKIP_ZERO_TO_ACC, 8'h00, 8'h05, 1'b1, 6'h21);
    chk(acc_result, 8'h04);
    run(OP_DECREMENT_SKIP_ZERO_TO_ACC, 8'h00, 8'h01, 1'b1, 6'h22);
    chk(acc_result, 8'h00);
    @(negedge ref_clk);
    chk({2'h0, st}, 8'h01);
    run(OP_DECREMENT_SKIP_ZERO_MEM, 8'h00, 8'h00, 1'b0, 6'h11);
    chk(mem_result, 8'hFF);
    idle();
  endtask
  // ****************************************
  // clock, timeout and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 500) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = OP_ROTATE_RIGHT_MEM;
    accumulator = 8'h00;
    mem_operand = 8'h00;
    carry_flag = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk({1'b0, op_ready, st}, 8'h40);
    t_rot();
    t_sub();
    t_dec();
    complete_run();
  end
endmodule
`default_nettype wire
